// ===== hw/fnsc_regs.svh
// What this block does
// - recompute divide value and pulse-removal command every 10 us reference period
// - during sweep step frequency up or down; flag on reaching start or stop
// - during upward sweep also flag on reaching the marker frequency
// - integer divide value is three BCD digits held between 300 and 500
// - issue the bias discharge pulse right after each sample instant
// - accumulate the fractional phase difference in an internal accumulator
// - present the phase interpolation value as a five-line parallel code
// - accumulator passing unity commands divide by N plus one that period
// - add twelve fraction digits to twelve-digit accumulator; carry means removal
// - counter preset is 999 minus the divide value, nine's complement BCD
`ifndef FNSC_REGS_SVH
`define FNSC_REGS_SVH
// ****************
// timing
// ****************
`define FNSC_CLK_MHZ 25
`define FNSC_REF_US 10
`define FNSC_REF_CYC (`FNSC_REF_US * `FNSC_CLK_MHZ)
`define FNSC_BIAS_NS 1000
`define FNSC_BIAS_CYC ((`FNSC_BIAS_NS * `FNSC_CLK_MHZ) / 1000)
// ****************
// frequency word layout and limits
// ****************
`define FNSC_FREQ_DIGITS 15
`define FNSC_FRAC_DIGITS 12
`define FNSC_N_MIN 12'h300
`define FNSC_N_MAX 12'h500
`define FNSC_PRESET_ALL9 12'h999
`define FNSC_CODE_SCALE 32
`define FNSC_CODE_DIV 100
`endif

// ===== hw/fnsc_pkg.sv
package fnsc_pkg;
   // bias discharge phase
   typedef enum logic [0:0] {
      BIAS_IDLE = 1'b0,
      BIAS_ON = 1'b1
   } fnsc_bias_e;
   // whole state of the controller
   typedef struct packed {
      logic [59:0] freq;
      logic [59:0] pend;
      logic pend_v;
      logic active;
      logic [47:0] acc;
      logic [11:0] preset;
      logic rem;
      logic [4:0] code;
      logic limit;
      logic samp;
      fnsc_bias_e bias;
      logic [4:0] bias_cnt;
      logic [2:0] cs_sync;
   } fnsc_state_s;
endpackage : fnsc_pkg

// ===== hw/fnsc_add_if.sv
`timescale 1ns/10ps
`default_nettype none
// operands and result of one BCD adder
interface fnsc_add_if #(parameter int DIGITS = 12);
   logic [4*DIGITS-1:0] a;
   logic [4*DIGITS-1:0] b;
   logic cin;
   logic [4*DIGITS-1:0] sum;
   logic cout;
   modport adder(input a, input b, input cin, output sum, output cout);
   modport user(output a, output b, output cin, input sum, input cout);
endinterface : fnsc_add_if
`default_nettype wire

// ===== hw/fnsc_bcd_add.sv
`timescale 1ns/10ps
`default_nettype none
// ripple BCD adder, one decimal digit per nibble
module fnsc_bcd_add #(parameter int DIGITS = 12) (
   fnsc_add_if.adder io
);
   // digit-wise add with decimal carry
   always_comb begin
      logic c;
      logic [4:0] t;
      c = io.cin;
      t = 5'h00;
      io.sum = '0;
      for (int i = 0; i < DIGITS; i++) begin
         t = {1'b0, io.a[4*i+:4]} + {1'b0, io.b[4*i+:4]} + {4'h0, c};
         if (t > 5'h09) begin
            io.sum[4*i+:4] = 4'(t - 5'h0A);
            c = 1'b1;
         end else begin
            io.sum[4*i+:4] = t[3:0];
            c = 1'b0;
         end
      end
      io.cout = c;
   end
endmodule : fnsc_bcd_add
`default_nettype wire

// ===== hw/fnsc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fnsc_regs.svh"
module fnsc_top
   import fnsc_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // frequency programming
   input wire logic [59:0] FREQ_BCD,
   input wire logic FREQ_LOAD,
   // sweep setup
   input wire logic SWEEP_EN,
   input wire logic SWEEP_UP,
   input wire logic [59:0] SWEEP_STEP,
   input wire logic [59:0] SWEEP_START,
   input wire logic [59:0] SWEEP_STOP,
   input wire logic [59:0] SWEEP_MARKER,
   // divider side
   input wire logic CYCLE_START,
   output logic [11:0] PRESET_BCD,
   output logic PULSE_REMOVE,
   // loop analog side
   output logic [4:0] PHASE_INTERP_CODE,
   output logic SAMPLE_HOLD,
   output logic BIAS_PULSE,
   // status
   output logic SWEEP_LIMIT,
   output logic [59:0] FREQ_NOW
);
   // ****************
   // declarations
   // ****************
   fnsc_state_s st;
   fnsc_state_s next_st;
   logic cs_tick;
   logic [59:0] eff;
   logic [11:0] n_clamp;
   logic [7:0] top_pair;
   logic [11:0] code_wide;
   logic sw_hit_end;
   logic sw_hit_mark;
   logic [59:0] sw_val;
   fnsc_add_if #(.DIGITS(`FNSC_FRAC_DIGITS)) acc_io ();
   fnsc_add_if #(.DIGITS(`FNSC_FREQ_DIGITS)) sw_io ();

   // nine's complement of every digit
   function automatic logic [59:0] nines(input logic [59:0] v);
      logic [59:0] r;
      r = '0;
      for (int i = 0; i < `FNSC_FREQ_DIGITS; i++) begin
         r[4*i+:4] = 4'h9 - v[4*i+:4];
      end
      return r;
   endfunction : nines

   // ****************
   // adders
   // ****************
   // phase accumulator adder
   assign acc_io.a = st.acc;
   assign acc_io.b = eff[47:0];
   assign acc_io.cin = 1'b0;
   fnsc_bcd_add #(.DIGITS(`FNSC_FRAC_DIGITS)) u_acc_add (
      .io(acc_io)
   );
   // sweep stepper, down uses nine's complement plus one
   assign sw_io.a = st.freq;
   assign sw_io.b = SWEEP_UP ? SWEEP_STEP : nines(SWEEP_STEP);
   assign sw_io.cin = ~SWEEP_UP;
   fnsc_bcd_add #(.DIGITS(`FNSC_FREQ_DIGITS)) u_sw_add (
      .io(sw_io)
   );

   // ****************
   // cycle work
   // ****************
   // strobe edge from the synchronised divider pin
   // flops 0 and 1 absorb metastability, flop 2 keeps the old level for the edge
   assign cs_tick = st.cs_sync[1] & ~st.cs_sync[2];
   // pending frequency is used from the cycle that adopts it
   assign eff = st.pend_v ? st.pend : st.freq;
   // divide value held inside its legal range
   always_comb begin
      if (eff[59:48] < `FNSC_N_MIN) begin
         n_clamp = `FNSC_N_MIN;
      end else if (eff[59:48] > `FNSC_N_MAX) begin
         n_clamp = `FNSC_N_MAX;
      end else begin
         n_clamp = eff[59:48];
      end
   end
   // top two accumulator digits scaled onto five lines
   assign top_pair = {4'h0, acc_io.sum[47:44]} * 8'h0A + {4'h0, acc_io.sum[43:40]};
   assign code_wide = ({4'h0, top_pair} * 12'(`FNSC_CODE_SCALE)) / 12'(`FNSC_CODE_DIV);
   // sweep end and marker detection
   always_comb begin
      if (SWEEP_UP) begin
         sw_hit_end = sw_io.cout || (sw_io.sum >= SWEEP_STOP);
         sw_hit_mark = (st.freq < SWEEP_MARKER) && (sw_io.sum >= SWEEP_MARKER);
         sw_val = sw_hit_end ? SWEEP_STOP : sw_io.sum;
      end else begin
         sw_hit_end = !sw_io.cout || (sw_io.sum <= SWEEP_START);
         sw_hit_mark = 1'b0;
         sw_val = sw_hit_end ? SWEEP_START : sw_io.sum;
      end
   end

   // next state
   always_comb begin
      next_st = st;
      next_st.cs_sync = {st.cs_sync[1:0], CYCLE_START};
      next_st.samp = 1'b0;
      if (FREQ_LOAD) begin
         next_st.pend = FREQ_BCD;
         next_st.pend_v = 1'b1;
      end
      // bias pulse timing after the sample strobe
      case (st.bias)
         BIAS_IDLE: begin
            if (st.samp) begin
               next_st.bias = BIAS_ON;
               next_st.bias_cnt = 5'(`FNSC_BIAS_CYC - 1);
            end
         end
         BIAS_ON: begin
            if (st.bias_cnt == 5'h00) begin
               next_st.bias = BIAS_IDLE;
            end else begin
               next_st.bias_cnt = st.bias_cnt - 5'h01;
            end
         end
         default: begin
            next_st.bias = BIAS_IDLE;
         end
      endcase
      if (cs_tick) begin
         next_st.samp = 1'b1;
         next_st.limit = 1'b0;
         if (st.pend_v && !FREQ_LOAD) begin
            next_st.pend_v = 1'b0;
         end
         next_st.freq = eff;
         next_st.active = st.active | st.pend_v;
         next_st.preset = `FNSC_PRESET_ALL9 - n_clamp;
         next_st.acc = acc_io.sum;
         // removal stays idle until a frequency has been adopted
         next_st.rem = acc_io.cout & (st.active | st.pend_v);
         next_st.code = code_wide[4:0];
         if (SWEEP_EN && st.active && !st.pend_v) begin
            next_st.freq = sw_val;
            next_st.limit = sw_hit_end | sw_hit_mark;
         end
      end
   end

   // state register
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state
   assign PRESET_BCD = st.preset;
   assign PULSE_REMOVE = st.rem;
   assign PHASE_INTERP_CODE = st.code;
   assign SAMPLE_HOLD = st.samp;
   assign BIAS_PULSE = (st.bias == BIAS_ON);
   assign SWEEP_LIMIT = st.limit;
   assign FREQ_NOW = st.freq;

   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   // preset, accumulator and removal
   a_preset_nines: assert property (cs_tick |=> (st.preset + $past(n_clamp)) == 12'h999)
      else $error("preset is not the nine's complement");
   a_n_range: assert property (st.active |-> (st.preset >= 12'h499 && st.preset <= 12'h699))
      else $error("preset out of range");
   a_remove_carry: assert property (cs_tick && st.active
      |=> PULSE_REMOVE == $past(acc_io.cout))
      else $error("pulse removal does not follow carry");
   a_acc_store: assert property (cs_tick |=> st.acc == $past(acc_io.sum))
      else $error("accumulator sum not stored");
   a_remove_idle: assert property (!st.active |-> !PULSE_REMOVE)
      else $error("pulse removal before programming");
   // strobe and bias timing
   a_bias_after: assert property (cs_tick |=> SAMPLE_HOLD ##1 BIAS_PULSE [*8])
      else $error("bias pulse did not follow sample");
   a_sample_single: assert property (SAMPLE_HOLD |=> !SAMPLE_HOLD)
      else $error("sample strobe longer than one cycle");
   a_code_hold: assert property (!cs_tick |=> $stable(PHASE_INTERP_CODE))
      else $error("interpolation code changed mid cycle");
   a_load_defer: assert property (FREQ_LOAD && !cs_tick |=> $stable(PRESET_BCD))
      else $error("new frequency applied early");
   a_adopt_pend: assert property (cs_tick && st.pend_v |=> FREQ_NOW == $past(st.pend))
      else $error("pending frequency not adopted");
   // sweep flag
   a_limit_end: assert property (cs_tick && SWEEP_EN && st.active && !st.pend_v
      && sw_hit_end |=> SWEEP_LIMIT && FREQ_NOW == $past(sw_val))
      else $error("sweep end not flagged");
   a_limit_mark: assert property (cs_tick && SWEEP_EN && st.active && !st.pend_v
      && sw_hit_mark |=> SWEEP_LIMIT)
      else $error("marker not flagged");
   a_limit_drop: assert property (cs_tick && !(SWEEP_EN && st.active && !st.pend_v)
      |=> !SWEEP_LIMIT)
      else $error("sweep limit left standing");
   // main scenarios reached
   c_remove: cover property (cs_tick ##1 PULSE_REMOVE);
   c_limit: cover property (SWEEP_EN ##[1:1000] SWEEP_LIMIT);
   c_bias: cover property (SAMPLE_HOLD ##1 BIAS_PULSE);
   c_adopt: cover property (cs_tick && st.pend_v);
   c_down_end: cover property (!SWEEP_UP ##1 SWEEP_LIMIT);
endmodule : fnsc_top
`default_nettype wire

// ===== sim/fnsc_div_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// divider model: one cycle-start strobe per reference period
// ****************
module fnsc_div_model #(parameter int PERIOD = 60) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // strobe toward the controller
   output logic cycle_start
);
   int cnt;
   // strobe launched off the falling edge, one clock wide, silent in reset
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         cycle_start <= 1'b0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         cycle_start <= (cnt == PERIOD - 1);
      end
   end
endmodule : fnsc_div_model
`default_nettype wire

// ===== sim/fractional_n_synth_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module fractional_n_synth_control_test;
   import fnsc_pkg::*;
   logic mclk, rst_n, freq_load, sweep_en, sweep_up, cycle_start;
   logic [59:0] freq_bcd, step, start, stop, marker, freq_now;
   logic [11:0] preset;
   logic [4:0] code;
   logic rem, samp, bias, limit;
   int n_mismatch = 0;
   int comparisons = 0;
   fnsc_top i_fnsc_top (.MCLK(mclk), .RST_N(rst_n), .FREQ_BCD(freq_bcd),
      .FREQ_LOAD(freq_load), .SWEEP_EN(sweep_en), .SWEEP_UP(sweep_up),
      .SWEEP_STEP(step), .SWEEP_START(start), .SWEEP_STOP(stop),
      .SWEEP_MARKER(marker), .CYCLE_START(cycle_start), .PRESET_BCD(preset),
      .PULSE_REMOVE(rem), .PHASE_INTERP_CODE(code), .SAMPLE_HOLD(samp),
      .BIAS_PULSE(bias), .SWEEP_LIMIT(limit), .FREQ_NOW(freq_now));
   fnsc_div_model #(.PERIOD(60)) i_fnsc_div_model (.clk(mclk), .rst_n(rst_n),
      .cycle_start(cycle_start));
   // ****************
   // shared tasks
   // ****************
   task automatic chk(input logic [59:0] got, input logic [59:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // returns just after the update edge of the next reference cycle
   task automatic next_cycle();
      for (int i = 0; i < 200; i++) begin
         @(posedge mclk);
         #1;
         if (samp === 1'b1) return;
      end
      chk(1'b0, 1'b1);
   endtask : next_cycle
   task automatic load(input logic [59:0] v);
      @(negedge mclk);
      freq_bcd = v;
      freq_load = 1'b1;
      @(negedge mclk);
      freq_load = 1'b0;
   endtask : load
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   // ****************
   // scenarios
   // ****************
   task automatic t_reset();
      chk(rem, 1'b0);
      chk(limit, 1'b0);
      next_cycle();
      chk(rem, 1'b0);
   endtask : t_reset
   // fraction .4: carries on the third and fifth cycle
   task automatic t_accumulate();
      logic [4:0] codes [5] = '{5'h0C, 5'h19, 5'h06, 5'h13, 5'h00};
      logic rems [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      load(60'h400400000000000);
      for (int i = 0; i < 5; i++) begin
         next_cycle();
         chk(rem, rems[i]);
         chk(code, codes[i]);
      end
      chk(preset, 12'h599);
      chk(freq_now, 60'h400400000000000);
   endtask : t_accumulate
   task automatic t_bias();
      next_cycle();
      for (int i = 0; i < 26; i++) begin
         @(posedge mclk);
         #1;
         chk(bias, i < 25);
         chk(samp, 1'b0);
      end
   endtask : t_bias
   // out-of-range N clamped; adoption waits for the next cycle
   task automatic t_clamp();
      load(60'h250000000000000);
      chk(freq_now, 60'h400400000000000);
      next_cycle();
      chk(preset, 12'h699);
      load(60'h600000000000000);
      next_cycle();
      chk(preset, 12'h499);
      chk(rem, 1'b0);
   endtask : t_clamp
   task automatic t_sweep();
      logic [59:0] f [5] = '{60'h300000000000000, 60'h301000000000000,
         60'h302000000000000, 60'h301000000000000, 60'h300000000000000};
      logic lim [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      @(negedge mclk);
      sweep_en = 1'b1;
      sweep_up = 1'b1;
      load(60'h300000000000000);
      for (int i = 0; i < 5; i++) begin
         next_cycle();
         chk(freq_now, f[i]);
         if (i > 0) chk(limit, lim[i]);
         @(negedge mclk);
         if (i == 2) sweep_up = 1'b0;
      end
      sweep_en = 1'b0;
   endtask : t_sweep
   // ****************
   // clock, reset, sequence and watchdog
   // ****************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      rst_n = 1'b0;
      freq_load = 1'b0;
      freq_bcd = '0;
      sweep_en = 1'b0;
      sweep_up = 1'b0;
      step = 60'h001000000000000;
      start = 60'h300000000000000;
      stop = 60'h302000000000000;
      marker = 60'h301000000000000;
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      t_reset();
      t_accumulate();
      t_bias();
      t_clamp();
      t_sweep();
      conclude();
   end
   initial begin
      #400000;
      n_mismatch++;
      conclude();
   end
endmodule : fractional_n_synth_control_test
`default_nettype wire
